// ---- ppfs_pkg.sv ----
package ppfs_pkg;
  // Timing
  localparam int PPFS_CLK_PERIOD_NS = 25;
  localparam int PPFS_RST_MIN_LOW_NS = 2500;
  localparam int PPFS_RST_MIN_CYC =
    (PPFS_RST_MIN_LOW_NS + PPFS_CLK_PERIOD_NS - 1) / PPFS_CLK_PERIOD_NS;
  localparam int PPFS_RST_CNT_W = 8;
  localparam logic [PPFS_RST_CNT_W-1:0] PPFS_RST_LAST = PPFS_RST_CNT_W'(PPFS_RST_MIN_CYC - 1);
  // Widths
  localparam int PPFS_ADDR_W = 8;
  localparam int PPFS_DATA_W = 32;
  localparam int PPFS_PORT_W = 8;
  localparam int PPFS_NUM_PORTS = 3;
  localparam logic [7:0] PPFS_MASK_FULL = 8'hFF;
  localparam logic [7:0] PPFS_MASK_SECOND = 8'h7F;
  // Port indices and special bits
  localparam logic [1:0] PPFS_PORT_FIRST = 2'h0;
  localparam logic [1:0] PPFS_PORT_SECOND = 2'h1;
  localparam logic [1:0] PPFS_PORT_THIRD = 2'h2;
  localparam int PPFS_OSC_IN_BIT = 6;
  localparam int PPFS_OSC_OUT_BIT = 7;
  localparam int PPFS_RST_PIN_BIT = 6;
  // Register map: one 16-byte slot per port, then control and status
  localparam int PPFS_SLOT_LSB = 4;
  localparam int PPFS_FIELD_LSB = 2;
  localparam logic [1:0] PPFS_FLD_DIR = 2'h0;
  localparam logic [1:0] PPFS_FLD_OUT = 2'h1;
  localparam logic [1:0] PPFS_FLD_PULL = 2'h2;
  localparam logic [1:0] PPFS_FLD_PIN = 2'h3;
  localparam logic [7:0] PPFS_OFF_CTRL = 8'h30;
  localparam logic [7:0] PPFS_OFF_STAT = 8'h34;
  localparam int PPFS_CTRL_ASYNC_BIT = 0;
  localparam int PPFS_STAT_FUSE_BIT = 0;
  localparam int PPFS_STAT_CLK_LSB = 1;
  localparam int PPFS_STAT_RSTREQ_BIT = 3;
  localparam int PPFS_STAT_TIMER_BIT = 4;
  // Bus answers
  localparam logic [1:0] PPFS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPFS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PPFS_CLK_RC = 2'b00,
    PPFS_CLK_XTAL = 2'b01,
    PPFS_CLK_EXT = 2'b10,
    PPFS_CLK_RSVD = 2'b11
  } ppfs_clksrc_t;

  typedef enum logic {
    PPFS_WR_IDLE = 1'b0,
    PPFS_WR_RESP = 1'b1
  } ppfs_wr_state_t;

  typedef enum logic {
    PPFS_RD_IDLE = 1'b0,
    PPFS_RD_DATA = 1'b1
  } ppfs_rd_state_t;
endpackage

// ---- ppfs_rst_if.sv ----
`timescale 1ns/1ps
interface ppfs_rst_if;
  logic pin_level;
  logic func_en;
  logic req;
  modport filt (input pin_level, input func_en, output req);
  modport core (output pin_level, output func_en, input req);
endinterface

// ---- ppfs_rst_filter.sv ----
`timescale 1ns/1ps
module ppfs_rst_filter
  import ppfs_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reset pin path
  ppfs_rst_if.filt rif
);
  logic [PPFS_RST_CNT_W-1:0] cnt_r;
  logic req_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rif.func_en || rif.pin_level)
    begin
      cnt_r <= '0;
      req_r <= 1'b0;
    end
    else if (cnt_r == PPFS_RST_LAST)
      req_r <= 1'b1;
    else
      cnt_r <= cnt_r + 1'b1;
  end

  assign rif.req = req_r;

  sequence s_req_rise;
    $rose(req_r);
  endsequence

  property p_req_after_run;
    @(posedge aclk) disable iff (!aresetn)
    s_req_rise |-> $past(cnt_r) == PPFS_RST_LAST && $past(rif.func_en);
  endproperty

  chk_req_after_run: assert property (p_req_after_run)
    else $error("reset request without full low time");

  chk_req_drops_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    req_r && rif.pin_level |=> !req_r)
    else $error("reset request held after pin went high");
endmodule

// ---- ppfs_top.sv ----
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module ppfs_top
  import ppfs_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [PPFS_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [PPFS_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [PPFS_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [PPFS_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Non-volatile options
  input wire logic reset_pin_disable_fuse,
  input wire logic [1:0] clock_select_fuse,
  // First port pins
  input wire logic [7:0] first_port_i,
  output logic [7:0] first_port_o,
  output logic [7:0] first_port_oe,
  output logic [7:0] first_port_pu,
  // Second port pins
  input wire logic [6:0] second_port_i,
  output logic [6:0] second_port_o,
  output logic [6:0] second_port_oe,
  output logic [6:0] second_port_pu,
  // Third port pins
  input wire logic [7:0] third_port_i,
  output logic [7:0] third_port_o,
  output logic [7:0] third_port_oe,
  output logic [7:0] third_port_pu,
  // Alternate functions
  output logic clk_circuit_in,
  output logic xtal_amp_en,
  output logic timer_osc_en,
  output logic timer_osc_in,
  output logic device_reset_req
);
  logic [7:0] dir_r [0:PPFS_NUM_PORTS-1];
  logic [7:0] out_r [0:PPFS_NUM_PORTS-1];
  logic [7:0] pull_r [0:PPFS_NUM_PORTS-1];
  logic [7:0] in_s1_r [0:PPFS_NUM_PORTS-1];
  logic [7:0] in_s2_r [0:PPFS_NUM_PORTS-1];
  logic [7:0] pin_oe_r [0:PPFS_NUM_PORTS-1];
  logic [7:0] pin_o_r [0:PPFS_NUM_PORTS-1];
  logic [7:0] pin_pu_r [0:PPFS_NUM_PORTS-1];
  logic [7:0] oe_nxt [0:PPFS_NUM_PORTS-1];
  logic [7:0] o_nxt [0:PPFS_NUM_PORTS-1];
  logic [7:0] pu_nxt [0:PPFS_NUM_PORTS-1];
  logic async_sel_r;
  logic fuse_lat_r;
  ppfs_clksrc_t clksel_r;
  logic rst_fn;
  logic xtal_mode;
  logic ext_mode;
  logic timer_mode;
  logic pins_rst_n;
  logic core_rst_n;
  logic dev_req_r;
  logic clk_in_r;
  logic xtal_en_r;
  logic timer_en_r;
  logic timer_in_r;
  ppfs_wr_state_t wr_state_r;
  ppfs_rd_state_t rd_state_r;
  logic aw_got_r;
  logic w_got_r;
  logic [PPFS_ADDR_W-1:0] aw_addr_r;
  logic [PPFS_DATA_W-1:0] w_data_r;
  logic w_lane0_r;
  logic do_write;
  logic [1:0] wr_port;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [PPFS_DATA_W-1:0] rdata_r;
  logic [PPFS_DATA_W-1:0] rd_nxt;
  logic rd_err_nxt;
  logic [1:0] rd_port;

  function automatic logic [1:0] port_of(input logic [PPFS_ADDR_W-1:0] a);
    port_of = a[PPFS_SLOT_LSB +: 2];
  endfunction

  function automatic logic [1:0] field_of(input logic [PPFS_ADDR_W-1:0] a);
    field_of = a[PPFS_FIELD_LSB +: 2];
  endfunction

  function automatic logic addr_hit(input logic [PPFS_ADDR_W-1:0] a);
    addr_hit = (a[1:0] == 2'h0) && (a <= PPFS_OFF_STAT);
  endfunction

  function automatic logic [7:0] port_mask(input logic [1:0] p);
    port_mask = (p == PPFS_PORT_SECOND) ? PPFS_MASK_SECOND : PPFS_MASK_FULL;
  endfunction

  ppfs_rst_if rif ();

  ppfs_rst_filter u_rst_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .rif(rif)
  );

  assign rst_fn = !fuse_lat_r;
  assign rif.pin_level = in_s2_r[PPFS_PORT_SECOND][PPFS_RST_PIN_BIT];
  assign rif.func_en = rst_fn;
  assign xtal_mode = (clksel_r == PPFS_CLK_XTAL);
  assign ext_mode = (clksel_r == PPFS_CLK_EXT);
  assign timer_mode = (clksel_r == PPFS_CLK_RC) && async_sel_r;
  // async pin release path, no clock needed
  assign pins_rst_n = aresetn &&
    (reset_pin_disable_fuse || second_port_i[PPFS_RST_PIN_BIT]);
  // filtered pin reset resets the device logic
  assign core_rst_n = aresetn && !dev_req_r;

  // Option bits caught while reset is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fuse_lat_r <= reset_pin_disable_fuse;
      clksel_r <= ppfs_clksrc_t'(clock_select_fuse);
    end
  end

  // Two-stage pin input synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int p = 0; p < PPFS_NUM_PORTS; p++)
      begin
        in_s1_r[p] <= '0;
        in_s2_r[p] <= '0;
      end
    end
    else
    begin
      in_s1_r[PPFS_PORT_FIRST] <= first_port_i;
      in_s1_r[PPFS_PORT_SECOND] <= {1'b0, second_port_i};
      in_s1_r[PPFS_PORT_THIRD] <= third_port_i;
      for (int p = 0; p < PPFS_NUM_PORTS; p++)
        in_s2_r[p] <= in_s1_r[p];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dev_req_r <= 1'b0;
    else
      dev_req_r <= rif.req;
  end

  // Pin control with overrides applied
  always_comb
  begin
    for (int p = 0; p < PPFS_NUM_PORTS; p++)
    begin
      oe_nxt[p] = dir_r[p];
      o_nxt[p] = out_r[p];
      pu_nxt[p] = pull_r[p] & ~dir_r[p];
    end
    if (xtal_mode || ext_mode)
    begin
      oe_nxt[PPFS_PORT_FIRST][PPFS_OSC_IN_BIT] = 1'b0;
      o_nxt[PPFS_PORT_FIRST][PPFS_OSC_IN_BIT] = 1'b0;
      pu_nxt[PPFS_PORT_FIRST][PPFS_OSC_IN_BIT] = 1'b0;
    end
    if (xtal_mode)
    begin
      oe_nxt[PPFS_PORT_FIRST][PPFS_OSC_OUT_BIT] = 1'b1;
      o_nxt[PPFS_PORT_FIRST][PPFS_OSC_OUT_BIT] =
        !in_s2_r[PPFS_PORT_FIRST][PPFS_OSC_IN_BIT];
      pu_nxt[PPFS_PORT_FIRST][PPFS_OSC_OUT_BIT] = 1'b0;
    end
    // timer oscillator owns both top bits
    if (timer_mode)
    begin
      oe_nxt[PPFS_PORT_FIRST][PPFS_OSC_OUT_BIT -: 2] = 2'h0;
      o_nxt[PPFS_PORT_FIRST][PPFS_OSC_OUT_BIT -: 2] = 2'h0;
      pu_nxt[PPFS_PORT_FIRST][PPFS_OSC_OUT_BIT -: 2] = 2'h0;
    end
    if (rst_fn)
    begin
      oe_nxt[PPFS_PORT_SECOND][PPFS_RST_PIN_BIT] = 1'b0;
      o_nxt[PPFS_PORT_SECOND][PPFS_RST_PIN_BIT] = 1'b0;
      pu_nxt[PPFS_PORT_SECOND][PPFS_RST_PIN_BIT] = 1'b1;
    end
  end

  // pins float while aresetn is low or, with the fuse unprogrammed, the raw reset pin is low
  always_ff @(posedge aclk or negedge pins_rst_n)
  begin
    if (!pins_rst_n)
    begin
      for (int p = 0; p < PPFS_NUM_PORTS; p++)
      begin
        pin_oe_r[p] <= '0;
        pin_o_r[p] <= '0;
        pin_pu_r[p] <= '0;
      end
    end
    else
    begin
      for (int p = 0; p < PPFS_NUM_PORTS; p++)
      begin
        pin_oe_r[p] <= oe_nxt[p];
        pin_o_r[p] <= o_nxt[p];
        pin_pu_r[p] <= pu_nxt[p];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!core_rst_n)
    begin
      clk_in_r <= 1'b0;
      xtal_en_r <= 1'b0;
      timer_en_r <= 1'b0;
      timer_in_r <= 1'b0;
    end
    else
    begin
      clk_in_r <= (xtal_mode || ext_mode) && in_s2_r[PPFS_PORT_FIRST][PPFS_OSC_IN_BIT];
      xtal_en_r <= xtal_mode;
      timer_en_r <= timer_mode;
      timer_in_r <= timer_mode && in_s2_r[PPFS_PORT_FIRST][PPFS_OSC_IN_BIT];
    end
  end

  assign do_write = (wr_state_r == PPFS_WR_IDLE) && aw_got_r && w_got_r;
  assign wr_port = port_of(aw_addr_r);

  // Port registers; per-bit storage
  always_ff @(posedge aclk)
  begin
    if (!core_rst_n)
    begin
      for (int p = 0; p < PPFS_NUM_PORTS; p++)
      begin
        dir_r[p] <= '0;
        out_r[p] <= '0;
        pull_r[p] <= '0;
      end
    end
    else if (do_write && w_lane0_r && addr_hit(aw_addr_r) && aw_addr_r < PPFS_OFF_CTRL)
    begin
      if (field_of(aw_addr_r) == PPFS_FLD_DIR)
        dir_r[wr_port] <= w_data_r[PPFS_PORT_W-1:0] & port_mask(wr_port);
      else if (field_of(aw_addr_r) == PPFS_FLD_OUT)
        out_r[wr_port] <= w_data_r[PPFS_PORT_W-1:0] & port_mask(wr_port);
      else if (field_of(aw_addr_r) == PPFS_FLD_PULL)
        pull_r[wr_port] <= w_data_r[PPFS_PORT_W-1:0] & port_mask(wr_port);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!core_rst_n)
      async_sel_r <= 1'b0;
    else if (do_write && w_lane0_r && aw_addr_r == PPFS_OFF_CTRL)
      async_sel_r <= w_data_r[PPFS_CTRL_ASYNC_BIT];
  end

  // Write channel handler
  always_ff @(posedge aclk)
  begin
    if (!core_rst_n)
    begin
      wr_state_r <= PPFS_WR_IDLE;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_lane0_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= PPFS_RESP_OKAY;
    end
    else
    begin
      case (wr_state_r)
        PPFS_WR_IDLE:
        begin
          if (awvalid && awready_r)
          begin
            aw_got_r <= 1'b1;
            aw_addr_r <= awaddr;
            awready_r <= 1'b0;
          end
          else if (!aw_got_r)
            awready_r <= 1'b1;
          if (wvalid && wready_r)
          begin
            w_got_r <= 1'b1;
            w_data_r <= wdata;
            w_lane0_r <= wstrb[0];
            wready_r <= 1'b0;
          end
          else if (!w_got_r)
            wready_r <= 1'b1;
          if (aw_got_r && w_got_r)
          begin
            wr_state_r <= PPFS_WR_RESP;
            bvalid_r <= 1'b1;
            bresp_r <= addr_hit(aw_addr_r) ? PPFS_RESP_OKAY : PPFS_RESP_SLVERR;
          end
        end
        PPFS_WR_RESP:
        begin
          if (bready)
          begin
            wr_state_r <= PPFS_WR_IDLE;
            bvalid_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
          end
        end
        default: wr_state_r <= PPFS_WR_IDLE;
      endcase
    end
  end

  // Read data selection
  always_comb
  begin
    rd_nxt = '0;
    rd_err_nxt = 1'b0;
    rd_port = port_of(araddr);
    if (!addr_hit(araddr))
      rd_err_nxt = 1'b1;
    else if (araddr == PPFS_OFF_CTRL)
      rd_nxt[PPFS_CTRL_ASYNC_BIT] = async_sel_r;
    else if (araddr == PPFS_OFF_STAT)
    begin
      rd_nxt[PPFS_STAT_FUSE_BIT] = fuse_lat_r;
      rd_nxt[PPFS_STAT_CLK_LSB +: 2] = clksel_r;
      rd_nxt[PPFS_STAT_RSTREQ_BIT] = dev_req_r;
      rd_nxt[PPFS_STAT_TIMER_BIT] = timer_mode;
    end
    else if (field_of(araddr) == PPFS_FLD_DIR)
      rd_nxt[PPFS_PORT_W-1:0] = dir_r[rd_port];
    else if (field_of(araddr) == PPFS_FLD_OUT)
      rd_nxt[PPFS_PORT_W-1:0] = out_r[rd_port];
    else if (field_of(araddr) == PPFS_FLD_PULL)
      rd_nxt[PPFS_PORT_W-1:0] = pull_r[rd_port];
    else
      rd_nxt[PPFS_PORT_W-1:0] = in_s2_r[rd_port] & port_mask(rd_port);
  end

  // Read channel handler
  always_ff @(posedge aclk)
  begin
    if (!core_rst_n)
    begin
      rd_state_r <= PPFS_RD_IDLE;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= PPFS_RESP_OKAY;
      rdata_r <= '0;
    end
    else
    begin
      case (rd_state_r)
        PPFS_RD_IDLE:
        begin
          if (arvalid && arready_r)
          begin
            rd_state_r <= PPFS_RD_DATA;
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_nxt;
            rresp_r <= rd_err_nxt ? PPFS_RESP_SLVERR : PPFS_RESP_OKAY;
          end
          else
            arready_r <= 1'b1;
        end
        PPFS_RD_DATA:
        begin
          if (rready)
          begin
            rd_state_r <= PPFS_RD_IDLE;
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
          end
        end
        default: rd_state_r <= PPFS_RD_IDLE;
      endcase
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign first_port_oe = pin_oe_r[PPFS_PORT_FIRST];
  assign first_port_o = pin_o_r[PPFS_PORT_FIRST];
  assign first_port_pu = pin_pu_r[PPFS_PORT_FIRST];
  assign second_port_oe = pin_oe_r[PPFS_PORT_SECOND][6:0];
  assign second_port_o = pin_o_r[PPFS_PORT_SECOND][6:0];
  assign second_port_pu = pin_pu_r[PPFS_PORT_SECOND][6:0];
  assign third_port_oe = pin_oe_r[PPFS_PORT_THIRD];
  assign third_port_o = pin_o_r[PPFS_PORT_THIRD];
  assign third_port_pu = pin_pu_r[PPFS_PORT_THIRD];
  assign clk_circuit_in = clk_in_r;
  assign xtal_amp_en = xtal_en_r;
  assign timer_osc_en = timer_en_r;
  assign timer_osc_in = timer_in_r;
  assign device_reset_req = dev_req_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_pins_live;
    pins_rst_n && $past(pins_rst_n);
  endsequence

  chk_first_gpio_dir: assert property (
    s_pins_live |-> first_port_oe[5:0] == $past(dir_r[PPFS_PORT_FIRST][5:0]))
    else $error("first port direction not applied");
  chk_second_gpio_dir: assert property (
    s_pins_live |-> second_port_oe[5:0] == $past(dir_r[PPFS_PORT_SECOND][5:0]))
    else $error("second port direction not applied");
  chk_third_gpio_out: assert property (
    s_pins_live |-> third_port_oe == $past(dir_r[PPFS_PORT_THIRD])
      && third_port_o == $past(out_r[PPFS_PORT_THIRD]))
    else $error("third port drive not applied");
  chk_pull_per_bit: assert property (
    s_pins_live |->
      third_port_pu == $past(pull_r[PPFS_PORT_THIRD] & ~dir_r[PPFS_PORT_THIRD]))
    else $error("pull-up does not follow its bit");
  chk_reset_tristate: assert property (
    disable iff (1'b0) !pins_rst_n |->
      first_port_oe == '0 && second_port_oe == '0 && third_port_oe == '0)
    else $error("pin driven during reset");
  chk_c6_gpio_mode: assert property (
    s_pins_live and $past(fuse_lat_r) |->
      second_port_oe[PPFS_RST_PIN_BIT] == $past(dir_r[PPFS_PORT_SECOND][PPFS_RST_PIN_BIT]))
    else $error("bit 6 not general I/O with fuse programmed");
  chk_c6_reset_pin: assert property (
    s_pins_live and $past(rst_fn) |->
      !second_port_oe[PPFS_RST_PIN_BIT] && second_port_pu[PPFS_RST_PIN_BIT])
    else $error("reset pin not held as input");
  chk_reset_request: assert property (
    $rose(rif.req) |=> device_reset_req ##1 !awready && !arready)
    else $error("filtered reset did not reset device");
  chk_osc_input: assert property (
    s_pins_live and $past(xtal_mode || ext_mode) |->
      !first_port_oe[PPFS_OSC_IN_BIT] && !first_port_pu[PPFS_OSC_IN_BIT])
    else $error("oscillator input pin still driven");
  chk_amp_output: assert property (
    s_pins_live and $past(xtal_mode) |-> first_port_oe[PPFS_OSC_OUT_BIT]
      && first_port_o[PPFS_OSC_OUT_BIT] == !$past(in_s2_r[PPFS_PORT_FIRST][PPFS_OSC_IN_BIT]))
    else $error("amplifier output wrong");
  chk_timer_pins: assert property (
    s_pins_live and $past(timer_mode) |->
      first_port_oe[7:6] == 2'h0 && first_port_pu[7:6] == 2'h0)
    else $error("timer oscillator pins not released");
endmodule

// ---- ppfs_board.sv ----
`timescale 1ns/1ps
module ppfs_board
(
  // Clock
  input wire logic aclk,
  // Device drive, packed third, second, first
  input wire logic [22:0] pin_o,
  input wire logic [22:0] pin_oe,
  input wire logic [22:0] pin_pu,
  // Outside drive
  input wire logic [22:0] ext_en,
  input wire logic [22:0] ext_val,
  // Resolved pin levels
  output logic [22:0] pin_lvl
);
  // Board resistor holds the reset line high
  localparam logic [22:0] BOARD_PULL = 23'h004000;
  logic [22:0] flt_r = 23'h2AAAAA;
  // Floating lines change every cycle
  always @(posedge aclk)
    flt_r <= ~flt_r;
  assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pu | BOARD_PULL))
    | (~pin_oe & ~ext_en & ~(pin_pu | BOARD_PULL) & flt_r);
endmodule

// ---- ppfs_top_tb.sv ----
`timescale 1ns/1ps
module ppfs_top_tb
  import ppfs_pkg::*;
  ;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic fuse = 1'b1;
  logic [1:0] csel = 2'h3;
  logic [7:0] p1_o, p1_oe, p1_pu, p3_o, p3_oe, p3_pu;
  logic [6:0] p2_o, p2_oe, p2_pu;
  logic [22:0] lvl;
  logic [22:0] ext_en = 23'h0, ext_val = 23'h0;
  logic clk_in, amp_en, tmr_en, tmr_in, rst_req;
  int errors = 0;
  int compares = 0;

  always #12.5 aclk = ~aclk;

  ppfs_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .reset_pin_disable_fuse(fuse), .clock_select_fuse(csel),
    .first_port_i(lvl[7:0]), .first_port_o(p1_o), .first_port_oe(p1_oe),
    .first_port_pu(p1_pu), .second_port_i(lvl[14:8]), .second_port_o(p2_o),
    .second_port_oe(p2_oe), .second_port_pu(p2_pu), .third_port_i(lvl[22:15]),
    .third_port_o(p3_o), .third_port_oe(p3_oe), .third_port_pu(p3_pu),
    .clk_circuit_in(clk_in), .xtal_amp_en(amp_en), .timer_osc_en(tmr_en),
    .timer_osc_in(tmr_in), .device_reset_req(rst_req));

  ppfs_board i_board (.aclk, .pin_o({p3_o, p2_o, p1_o}), .pin_oe({p3_oe, p2_oe, p1_oe}),
    .pin_pu({p3_pu, p2_pu, p1_pu}), .ext_en, .ext_val, .pin_lvl(lvl));

  task automatic conclude();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (40)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        return;
      end
    end
    chk(32'h0, 32'h1);
    conclude();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (40)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        rready <= 1'b0;
        chk(rdata, {24'h0, e});
        chk({30'h0, rresp}, {30'h0, er});
        return;
      end
    end
    chk(32'h0, 32'h1);
    conclude();
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic reboot(input logic f, input logic [1:0] c);
    @(posedge aclk);
    aresetn <= 1'b0;
    fuse <= f;
    csel <= c;
    ext_en <= 23'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic t_regs();
    wr(8'h00, 8'h0F, PPFS_RESP_OKAY);
    wr(8'h04, 8'hA5, PPFS_RESP_OKAY);
    wr(8'h08, 8'hF0, PPFS_RESP_OKAY);
    wr(8'h10, 8'hCF, PPFS_RESP_OKAY);
    wr(8'h18, 8'h30, PPFS_RESP_OKAY);
    wr(8'h14, 8'hFF, PPFS_RESP_OKAY);
    wr(8'h20, 8'h81, PPFS_RESP_OKAY);
    wr(8'h24, 8'h80, PPFS_RESP_OKAY);
    wr(8'h28, 8'h7E, PPFS_RESP_OKAY);
    ext_en <= {8'h7E, 15'h0};
    ext_val <= {8'h24, 15'h0};
    idle(4);
    chk({24'h0, p1_oe}, 32'h0F);
    chk({24'h0, p1_o & p1_oe}, 32'h05);
    chk({24'h0, p1_pu}, 32'hF0);
    chk({25'h0, p2_oe}, 32'h4F);
    chk({25'h0, p2_pu}, 32'h30);
    chk({25'h0, p2_o}, 32'h7F);
    chk({24'h0, p3_o}, 32'h80);
    chk({24'h0, p3_oe}, 32'h81);
    chk({24'h0, p3_pu}, 32'h7E);
    rd(8'h2C, 8'hA4, PPFS_RESP_OKAY);
    rd(8'h10, 8'h4F, PPFS_RESP_OKAY);
    rd(8'h34, 8'h07, PPFS_RESP_OKAY);
    wr(8'h34, 8'hFF, PPFS_RESP_OKAY);
    wr(8'h3C, 8'h01, PPFS_RESP_SLVERR);
    rd(8'h40, 8'h00, PPFS_RESP_SLVERR);
    $display("test regs done");
  endtask

  task automatic t_async();
    @(posedge aclk);
    aresetn <= 1'b0;
    #1;
    chk({9'h0, p3_oe, p2_oe, p1_oe}, 32'h0);
    chk({9'h0, p3_pu, p2_pu, p1_pu}, 32'h0);
    $display("test async done");
  endtask

  task automatic t_rstpin();
    int n;
    reboot(1'b0, 2'h3);
    wr(8'h10, 8'h7F, PPFS_RESP_OKAY);
    wr(8'h00, 8'hFF, PPFS_RESP_OKAY);
    idle(2);
    chk({25'h0, p2_oe}, 32'h3F);
    chk({31'h0, p2_pu[6]}, 32'h1);
    @(posedge aclk);
    ext_en <= 23'h4000;
    ext_val <= 23'h0;
    #1;
    chk({24'h0, p1_oe}, 32'h0);
    for (n = 0; n < 200 && rst_req !== 1'b1; n++)
      @(posedge aclk);
    chk({31'h0, n >= PPFS_RST_MIN_CYC && n <= PPFS_RST_MIN_CYC + 6}, 32'h1);
    if (n >= 200)
      conclude();
    ext_en <= 23'h0;
    for (n = 0; n < 10 && rst_req !== 1'b0; n++)
      @(posedge aclk);
    chk({31'h0, rst_req}, 32'h0);
    rd(8'h00, 8'h00, PPFS_RESP_OKAY);
    rd(8'h34, 8'h06, PPFS_RESP_OKAY);
    $display("test reset pin done");
  endtask

  task automatic t_xtal();
    reboot(1'b1, 2'h1);
    wr(8'h00, 8'h3F, PPFS_RESP_OKAY);
    wr(8'h08, 8'hFF, PPFS_RESP_OKAY);
    wr(8'h30, 8'h01, PPFS_RESP_OKAY);
    ext_en <= 23'h40;
    ext_val <= 23'h40;
    idle(4);
    chk({24'h0, p1_oe}, 32'hBF);
    chk({24'h0, p1_pu}, 32'h00);
    chk({28'h0, amp_en, tmr_en, clk_in, p1_o[7]}, 32'hA);
    @(posedge aclk);
    ext_val <= 23'h0;
    idle(4);
    chk({30'h0, clk_in, p1_o[7]}, 32'h1);
    reboot(1'b1, 2'h2);
    wr(8'h00, 8'hFF, PPFS_RESP_OKAY);
    ext_en <= 23'h40;
    ext_val <= 23'h40;
    idle(4);
    chk({24'h0, p1_oe}, 32'hBF);
    chk({28'h0, amp_en, tmr_en, clk_in, p1_o[7]}, 32'h2);
    $display("test crystal done");
  endtask

  task automatic t_timer();
    reboot(1'b1, 2'h0);
    wr(8'h00, 8'hFF, PPFS_RESP_OKAY);
    wr(8'h08, 8'hFF, PPFS_RESP_OKAY);
    wr(8'h30, 8'h01, PPFS_RESP_OKAY);
    ext_en <= 23'h40;
    ext_val <= 23'h40;
    idle(4);
    chk({24'h0, p1_oe}, 32'h3F);
    chk({24'h0, p1_pu}, 32'h00);
    chk({28'h0, amp_en, tmr_en, tmr_in, clk_in}, 32'h6);
    wr(8'h30, 8'h00, PPFS_RESP_OKAY);
    idle(3);
    chk({23'h0, tmr_en, p1_oe}, 32'hFF);
    $display("test timer done");
  endtask

  initial
  begin
    reboot(1'b1, 2'h3);
    t_regs();
    t_async();
    t_rstpin();
    t_xtal();
    t_timer();
    conclude();
  end
endmodule
